// ==== lnbfs_master.sv ====
// ****************************************
// two-wire bus master model
// ****************************************
module lnbfs_master (
	output logic      scl,
	output logic      sda_drv,
	input  wire logic sda
);
	timeunit 1ns;
	timeprecision 1ns;
	// a released line floats to the pull-up level, never the last value
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	// one bit: data moves mid-low, sampled mid-high
	task automatic xfer(input logic b, output logic r);
		#80 sda_drv = b;
		#80 scl = 1'b1;
		#80 r = sda;
		#80 scl = 1'b0;
	endtask
	task automatic start();
		#80 sda_drv = 1'b1;
		#80 scl = 1'b1;
		#80 sda_drv = 1'b0;
		#80 scl = 1'b0;
	endtask
	// long idle after stop keeps the write commit clear of the next start
	task automatic stop();
		#80 sda_drv = 1'b0;
		#80 scl = 1'b1;
		#80 sda_drv = 1'b1;
		#320;
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			xfer(d[i], r);
		end
		xfer(1'b1, r);
		ack = ~r;
	endtask
	// master acks each byte but the last
	task automatic rbyte(input logic more, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			xfer(1'b1, r);
			d[i] = r;
		end
		xfer(~more, r);
	endtask
endmodule

// ==== lnbfs_pkg.sv ====
package lnbfs_pkg;

	// ***********************************************************
	// timing
	// ***********************************************************
	localparam int unsigned CLK_HZ         = 25_000_000;
	localparam int unsigned OC_TIME_MS     = 48;
	// least time, whole milliseconds, so the product is exact
	localparam int unsigned OC_TIMEOUT_CYC = OC_TIME_MS * (CLK_HZ / 1000);

	// ***********************************************************
	// primary status byte layout
	// ***********************************************************
	localparam int unsigned OFF_BIT     = 0;
	localparam int unsigned OVERCUR_BIT = 2;
	localparam int unsigned PWR_BIT     = 4;
	localparam int unsigned THERM_BIT   = 6;
	localparam int unsigned SUPPLY_BIT  = 7;
	localparam logic [7:0]  SECONDARY_VALUE = 8'h00;

	// ***********************************************************
	// control byte layout and reset values
	// ***********************************************************
	localparam int unsigned VSEL_LSB     = 0;
	localparam int unsigned VSEL_MSB     = 3;
	localparam int unsigned TIMER_BIT    = 4;
	localparam int unsigned ENABLE_BIT   = 5;
	localparam int unsigned SEL_LSB      = 6;
	localparam int unsigned SEL_MSB      = 7;
	localparam logic [1:0]  CTRL_SEL_OUT = 2'h0;
	localparam logic [3:0]  VSEL_RST     = 4'h0;
	localparam logic        TIMER_RST    = 1'b1;
	localparam logic        OFF_RST      = 1'b1;
	// bus address of the device; value is arbitrary
	localparam logic [6:0]  DEV_ADDR_DEF = 7'h08;

	// ***********************************************************
	// carriers
	// ***********************************************************
	typedef struct packed {
		logic scl;
		logic sda;
		logic overcurrent;
		logic thermal;
		logic supply_low;
		logic below_85;
		logic within_90;
	} lnbfs_pins_type;

	// bus lines rest high; sync and edge history start there, so reset makes no false edge
	localparam lnbfs_pins_type PINS_IDLE = '{scl: 1'b1, sda: 1'b1, default: 1'b0};

	typedef struct packed {
		logic supply_low_flag;
		logic thermal_trip_flag;
		logic power_fault_flag;
		logic overcurrent_flag;
		logic output_off_flag;
	} lnbfs_flags_type;

	typedef enum logic [2:0] {
		BUS_IDLE, BUS_ADDR, BUS_ADDR_ACK, BUS_WR, BUS_WR_ACK, BUS_RD, BUS_RD_ACK
	} lnbfs_bus_state_type;

endpackage

// ==== lnbfs_status.sv ====
// What this block does
// - timed overcurrent beyond 48 ms turns output off, sets overcurrent and off flags
// - ninth clock rise of a read byte refreshes status, clears overcurrent when the overload timer is selected unless an overload trip sets it in that cycle
// - without overload timer, stay in current limit, overcurrent flag set meanwhile
// - without overload timer, overcurrent flag clears itself when overload ends
// - thermal shutdown from overload turns output off and sets thermal flag
// - power fault flag set when output on and voltage below 85 percent
// - power fault flag clears by itself once voltage within 90 percent
// - overtemperature turns output off, sets thermal and off flags
// - ninth read clock rise clears thermal flag only if condition gone
// - low input supply locks out output, sets supply low and off flags
// - after lockout output stays off until enable is written again
// - ninth read clock rise clears supply low flag only if condition gone
// - primary byte: off bit0, overcurrent bit2, power bit4, thermal bit6, supply bit7
// - secondary status byte is all zero
// - off flag set at reset, fault or disabling write, cleared after enabling write ends
// - read bytes alternate primary, secondary; each read starts with primary
module lnbfs_status
	import lnbfs_pkg::*;
#(
	parameter int unsigned OC_TIMEOUT = lnbfs_pkg::OC_TIMEOUT_CYC,
	parameter logic [6:0]  DEV_ADDR   = lnbfs_pkg::DEV_ADDR_DEF
) (
	input  wire logic                     clk,
	input  wire logic                     rst_b,
	input  wire logic                     scl_in,
	input  wire logic                     sda_in,
	output logic                          sda_out,
	output logic                          sda_oe,
	input  wire logic                     overcurrent_det,
	input  wire logic                     thermal_det,
	input  wire logic                     supply_low_det,
	input  wire logic                     vout_below_85,
	input  wire logic                     vout_within_90,
	output logic                          converter_supply_output,
	output logic [3:0]                    vsel,
	output logic                          overload_timer_select,
	output lnbfs_pkg::lnbfs_flags_type    flags
);
	import lnbfs_pkg::*;

	localparam int unsigned OCW = $clog2(OC_TIMEOUT + 1);

	initial begin
		if (OC_TIMEOUT < 1) $error("lnbfs_status: overload timeout must be at least one cycle");
	end

	// status byte layout
	// build a status byte; secondary carries nothing
	function automatic logic [7:0] status_byte(input logic sec, input lnbfs_flags_type f);
		logic [7:0] b;
		b = 8'h00;
		if (!sec) begin
			b[OFF_BIT]     = f.output_off_flag;
			b[OVERCUR_BIT] = f.overcurrent_flag;
			b[PWR_BIT]     = f.power_fault_flag;
			b[THERM_BIT]   = f.thermal_trip_flag;
			b[SUPPLY_BIT]  = f.supply_low_flag;
		end else begin
			b = SECONDARY_VALUE;
		end
		return b;
	endfunction

	// ***********************************************************
	// input conditioning
	// ***********************************************************
	lnbfs_pins_type pins_raw;
	lnbfs_pins_type pins_s;
	lnbfs_pins_type pins_prev_q;
	lnbfs_pins_type pins_prev_d;

	assign pins_raw = '{scl: scl_in, sda: sda_in, overcurrent: overcurrent_det,
		thermal: thermal_det, supply_low: supply_low_det,
		below_85: vout_below_85, within_90: vout_within_90};

	lnbfs_sync #(.W($bits(lnbfs_pins_type)), .RST_VAL(PINS_IDLE)) u_sync (
		.clk      (clk),
		.rst_b    (rst_b),
		.async_in (pins_raw),
		.sync_out (pins_s)
	);

	// edges are taken from the second stage only
	always_comb begin
		pins_prev_d = pins_s;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pins_prev_q <= PINS_IDLE;
		end else begin
			pins_prev_q <= pins_prev_d;
		end
	end

	logic scl_rise, scl_fall, bus_start, bus_stop;
	assign scl_rise  = pins_s.scl & ~pins_prev_q.scl;
	assign scl_fall  = ~pins_s.scl & pins_prev_q.scl;
	assign bus_start = pins_s.scl & pins_prev_q.scl & pins_prev_q.sda & ~pins_s.sda;
	assign bus_stop  = pins_s.scl & pins_prev_q.scl & ~pins_prev_q.sda & pins_s.sda;

	// ***********************************************************
	// serial bus slave
	// ***********************************************************
	lnbfs_bus_state_type state_q, state_d;
	logic [3:0] cnt_q, cnt_d;
	logic [7:0] shift_q, shift_d;
	logic       sda_oe_q, sda_oe_d;
	logic       sec_q, sec_d;
	logic       ack_q, ack_d;
	logic [7:0] wr_byte_q, wr_byte_d;
	logic       wr_valid_q, wr_valid_d;
	logic       refresh;
	logic       commit;
	lnbfs_flags_type flag_q, flag_d;

	always_comb begin
		state_d    = state_q;
		cnt_d      = cnt_q;
		shift_d    = shift_q;
		sda_oe_d   = sda_oe_q;
		sec_d      = sec_q;
		ack_d      = ack_q;
		wr_byte_d  = wr_byte_q;
		wr_valid_d = wr_valid_q;
		refresh    = 1'b0;
		commit     = 1'b0;
		if (bus_start) begin
			state_d    = BUS_ADDR;
			cnt_d      = 4'h0;
			sda_oe_d   = 1'b0;
			wr_valid_d = 1'b0;
		end else if (bus_stop) begin
			state_d    = BUS_IDLE;
			sda_oe_d   = 1'b0;
			commit     = wr_valid_q;
			wr_valid_d = 1'b0;
		end else begin
			unique case (state_q)
				BUS_IDLE: begin
				end
				BUS_ADDR, BUS_WR: begin
					if (scl_rise) begin
						shift_d = {shift_q[6:0], pins_s.sda};
						cnt_d   = cnt_q + 4'h1;
					end else if (scl_fall && cnt_q == 4'h8) begin
						if (state_q == BUS_WR) begin
							sda_oe_d   = 1'b1;
							wr_byte_d  = shift_q;
							wr_valid_d = 1'b1;
							state_d    = BUS_WR_ACK;
						end else if (shift_q[7:1] == DEV_ADDR) begin
							sda_oe_d = 1'b1;
							ack_d    = shift_q[0];
							state_d  = BUS_ADDR_ACK;
						end else begin
							state_d = BUS_IDLE;
						end
					end
				end
				BUS_ADDR_ACK: begin
					if (scl_fall) begin
						cnt_d = 4'h0;
						if (ack_q) begin
							shift_d  = status_byte(1'b0, flag_q);
							sda_oe_d = ~shift_d[7];
							sec_d    = 1'b1;
							state_d  = BUS_RD;
						end else begin
							sda_oe_d = 1'b0;
							state_d  = BUS_WR;
						end
					end
				end
				BUS_WR_ACK: begin
					if (scl_fall) begin
						sda_oe_d = 1'b0;
						cnt_d    = 4'h0;
						state_d  = BUS_WR;
					end
				end
				BUS_RD: begin
					if (scl_rise) begin
						cnt_d = cnt_q + 4'h1;
					end else if (scl_fall) begin
						if (cnt_q == 4'h8) begin
							sda_oe_d = 1'b0;
							state_d  = BUS_RD_ACK;
						end else begin
							shift_d  = {shift_q[6:0], 1'b0};
							sda_oe_d = ~shift_q[6];
						end
					end
				end
				BUS_RD_ACK: begin
					if (scl_rise) begin
						refresh = 1'b1;
						ack_d   = ~pins_s.sda;
					end else if (scl_fall) begin
						cnt_d = 4'h0;
						if (ack_q) begin
							shift_d  = status_byte(sec_q, flag_q);
							sda_oe_d = ~shift_d[7];
							sec_d    = ~sec_q;
							state_d  = BUS_RD;
						end else begin
							state_d = BUS_IDLE;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q    <= BUS_IDLE;
			cnt_q      <= 4'h0;
			shift_q    <= 8'h00;
			sda_oe_q   <= 1'b0;
			sec_q      <= 1'b0;
			ack_q      <= 1'b0;
			wr_byte_q  <= 8'h00;
			wr_valid_q <= 1'b0;
		end else begin
			state_q    <= state_d;
			cnt_q      <= cnt_d;
			shift_q    <= shift_d;
			sda_oe_q   <= sda_oe_d;
			sec_q      <= sec_d;
			ack_q      <= ack_d;
			wr_byte_q  <= wr_byte_d;
			wr_valid_q <= wr_valid_d;
		end
	end

	// ***********************************************************
	// fault flags and output control
	// ***********************************************************
	logic [OCW-1:0] oc_cnt_q, oc_cnt_d;
	logic           on_q, on_d;
	logic [3:0]     vsel_q, vsel_d;
	logic           tmr_q, tmr_d;
	logic           oc_trip;
	logic           ctrl_hit;

	assign ctrl_hit = commit && wr_byte_q[SEL_MSB:SEL_LSB] == CTRL_SEL_OUT;

	always_comb begin
		oc_cnt_d = '0;
		oc_trip  = 1'b0;
		flag_d   = flag_q;
		on_d     = on_q;
		vsel_d   = vsel_q;
		tmr_d    = tmr_q;
		if (pins_s.overcurrent && tmr_q && on_q) begin
			oc_cnt_d = oc_cnt_q + OCW'(1);
			oc_trip  = (oc_cnt_q == OCW'(OC_TIMEOUT - 1));
		end
		if (refresh)
			flag_d.overcurrent_flag = 1'b0;
		if (refresh && !pins_s.thermal)
			flag_d.thermal_trip_flag = 1'b0;
		// supply low cleared only when gone
		if (refresh && !pins_s.supply_low)
			flag_d.supply_low_flag = 1'b0;
		if (!tmr_q) begin
			flag_d.overcurrent_flag = pins_s.overcurrent;
		end
		if (pins_s.within_90)
			flag_d.power_fault_flag = 1'b0;
		// power fault while enabled and low
		if (on_q && pins_s.below_85)
			flag_d.power_fault_flag = 1'b1;
		// enabling write ends with no fault
		if (ctrl_hit) begin
			vsel_d = wr_byte_q[VSEL_MSB:VSEL_LSB];
			tmr_d  = wr_byte_q[TIMER_BIT];
			on_d   = wr_byte_q[ENABLE_BIT];
			flag_d.output_off_flag = ~wr_byte_q[ENABLE_BIT];
		end
		// overload trip, set wins over read clear
		if (oc_trip) begin
			flag_d.overcurrent_flag = 1'b1;
			flag_d.output_off_flag  = 1'b1;
			on_d                    = 1'b0;
		end
		if (pins_s.thermal) begin
			flag_d.thermal_trip_flag = 1'b1;
			flag_d.output_off_flag   = 1'b1;
			on_d                     = 1'b0;
		end
		// lockout; only a new enable write restores
		if (pins_s.supply_low) begin
			flag_d.supply_low_flag = 1'b1;
			flag_d.output_off_flag = 1'b1;
			on_d                   = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			oc_cnt_q <= '0;
			flag_q   <= '{output_off_flag: OFF_RST, default: 1'b0};
			on_q     <= 1'b0;
			vsel_q   <= VSEL_RST;
			tmr_q    <= TIMER_RST;
		end else begin
			oc_cnt_q <= oc_cnt_d;
			flag_q   <= flag_d;
			on_q     <= on_d;
			vsel_q   <= vsel_d;
			tmr_q    <= tmr_d;
		end
	end

	// open-drain: the pin is only ever pulled low
	assign sda_out                = 1'b0;
	assign sda_oe                 = sda_oe_q;
	assign converter_supply_output = on_q;
	assign vsel                   = vsel_q;
	assign overload_timer_select  = tmr_q;
	assign flags                  = flag_q;

endmodule

// ==== lnbfs_status_bench.sv ====
module lnbfs_status_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import lnbfs_pkg::*;
	logic            clk = 1'b0;
	logic            rst_b = 1'b0;
	logic            overcurrent_det = 1'b0;
	logic            thermal_det = 1'b0;
	logic            supply_low_det = 1'b0;
	logic            vout_below_85 = 1'b0;
	logic            vout_within_90 = 1'b1;
	logic            scl, sda_drv, sda_out, sda_oe, k;
	logic            converter_supply_output, overload_timer_select;
	logic [3:0]      vsel;
	lnbfs_flags_type flags;
	wire             sda = sda_drv & ~sda_oe;
	int              err_total = 0;
	int              checked = 0;
	int              cyc = 0;
	always #20 clk = ~clk;
	lnbfs_master m (.scl(scl), .sda_drv(sda_drv), .sda(sda));
	// short overload timeout keeps the run brief
	lnbfs_status #(.OC_TIMEOUT(20)) uut (.clk, .rst_b, .scl_in(scl), .sda_in(sda), .sda_out,
		.sda_oe, .overcurrent_det, .thermal_det, .supply_low_det, .vout_below_85,
		.vout_within_90, .converter_supply_output, .vsel, .overload_timer_select, .flags);
	task automatic close_out();
		$display("checked=%0d err_total=%0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// hang guard, well above the whole sequence
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			close_out();
		end
	end
	task automatic wt(int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic cmp(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic flag_chk(input logic [4:0] f, input logic on);
		cmp({2'h0, converter_supply_output, flags}, {2'h0, on, f});
	endtask
	// read three bytes in one transfer, then close it
	task automatic rd3(input logic [7:0] e1, input logic [7:0] e2, input logic [7:0] e3);
		logic [7:0] a, b, c;
		m.start();
		m.wbyte(8'h11, k);
		m.rbyte(1'b1, a);
		m.rbyte(1'b1, b);
		m.rbyte(1'b0, c);
		m.stop();
		cmp(a, e1);
		cmp(b, e2);
		cmp(c, e3);
	endtask
	task automatic wr(input logic [7:0] d);
		m.start();
		m.wbyte(8'h10, k);
		m.wbyte(d, k);
		m.stop();
		wt(4);
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		wt(12);
		rst_b = 1'b1;
		wt(6);
		flag_chk(5'h01, 1'b0);
		cmp({3'h0, overload_timer_select, vsel}, 8'h10);
		rd3(8'h01, 8'h00, 8'h01);
		wr(8'h35);
		cmp({3'h0, overload_timer_select, vsel}, 8'h15);
		rd3(8'h00, 8'h00, 8'h00);
		wr(8'h45);
		flag_chk(5'h00, 1'b1);
		overcurrent_det = 1'b1;
		wt(30);
		flag_chk(5'h03, 1'b0);
		overcurrent_det = 1'b0;
		wt(5);
		rd3(8'h05, 8'h00, 8'h01);
		wr(8'h25);
		overcurrent_det = 1'b1;
		wt(40);
		flag_chk(5'h02, 1'b1);
		overcurrent_det = 1'b0;
		wt(5);
		flag_chk(5'h00, 1'b1);
		wr(8'h35);
		thermal_det = 1'b1;
		wt(5);
		flag_chk(5'h09, 1'b0);
		rd3(8'h41, 8'h00, 8'h41);
		thermal_det = 1'b0;
		wt(5);
		rd3(8'h41, 8'h00, 8'h01);
		wr(8'h35);
		supply_low_det = 1'b1;
		wt(5);
		supply_low_det = 1'b0;
		wt(10);
		flag_chk(5'h11, 1'b0);
		rd3(8'h81, 8'h00, 8'h01);
		flag_chk(5'h01, 1'b0);
		wr(8'h35);
		flag_chk(5'h00, 1'b1);
		vout_within_90 = 1'b0;
		vout_below_85 = 1'b1;
		wt(5);
		rd3(8'h10, 8'h00, 8'h10);
		vout_below_85 = 1'b0;
		wt(5);
		flag_chk(5'h04, 1'b1);
		vout_within_90 = 1'b1;
		wt(5);
		flag_chk(5'h00, 1'b1);
		// untimed overload runs hot: thermal trip on top of the overcurrent flag
		wr(8'h25);
		overcurrent_det = 1'b1;
		wt(5);
		thermal_det = 1'b1;
		wt(5);
		flag_chk(5'h0b, 1'b0);
		overcurrent_det = 1'b0;
		thermal_det = 1'b0;
		wt(5);
		rd3(8'h41, 8'h00, 8'h01);
		m.start();
		m.wbyte(8'h12, k);
		m.stop();
		cmp({7'h0, k}, 8'h00);
		close_out();
	end
endmodule
bind lnbfs_status lnbfs_status_chk chk (.clk, .rst_b, .scl_in, .sda_in, .sda_out, .sda_oe,
	.overcurrent_det, .thermal_det, .supply_low_det, .vout_below_85, .vout_within_90,
	.converter_supply_output, .vsel, .overload_timer_select, .flags);

// ==== lnbfs_status_chk.sv ====
module lnbfs_status_chk
	import lnbfs_pkg::*;
(
	input wire logic                  clk,
	input wire logic                  rst_b,
	input wire logic                  scl_in,
	input wire logic                  sda_in,
	input wire logic                  sda_out,
	input wire logic                  sda_oe,
	input wire logic                  overcurrent_det,
	input wire logic                  thermal_det,
	input wire logic                  supply_low_det,
	input wire logic                  vout_below_85,
	input wire logic                  vout_within_90,
	input wire logic                  converter_supply_output,
	input wire logic [3:0]            vsel,
	input wire logic                  overload_timer_select,
	input wire lnbfs_pkg::lnbfs_flags_type flags
);
	// ****************************************
	// fault flag checks
	// ****************************************
	// windows allow two sync stages plus the register
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	chk_therm_off: assert property ($rose(thermal_det) |-> ##[2:5]
		(flags.thermal_trip_flag && flags.output_off_flag && !converter_supply_output))
		else $error("thermal trip did not shut output");
	chk_therm_hold: assert property (thermal_det [*6] |-> flags.thermal_trip_flag)
		else $error("thermal flag dropped while hot");
	chk_supply_off: assert property ($rose(supply_low_det) |-> ##[2:5]
		(flags.supply_low_flag && flags.output_off_flag && !converter_supply_output))
		else $error("supply low did not lock out");
	chk_pwr_set: assert property ($rose(vout_below_85) && converter_supply_output
		|-> ##[2:5] flags.power_fault_flag)
		else $error("power fault not set");
	chk_pwr_clear: assert property ((vout_within_90 && !vout_below_85) [*6]
		|-> !flags.power_fault_flag)
		else $error("power fault not cleared");
	chk_off_mirror: assert property (converter_supply_output != flags.output_off_flag)
		else $error("off flag disagrees with output");
	chk_on_at_stop: assert property ($rose(converter_supply_output)
		|-> scl_in && sda_in)
		else $error("output came on outside a stop");
	chk_untimed_set: assert property ($rose(overcurrent_det) && !overload_timer_select
		&& converter_supply_output |-> ##[2:5] (flags.overcurrent_flag && converter_supply_output))
		else $error("untimed overload misreported");
	chk_untimed_clr: assert property ($fell(overcurrent_det) && !overload_timer_select
		|-> ##[2:5] !flags.overcurrent_flag)
		else $error("untimed overcurrent flag stuck");
	chk_timed_off: assert property ($rose(flags.overcurrent_flag) && overload_timer_select
		|-> !converter_supply_output)
		else $error("timed overcurrent left output on");
	chk_drive_low: assert property (sda_oe |-> !sda_out)
		else $error("data pin driven high");
	cover property ($rose(flags.overcurrent_flag));
	cover property ($fell(flags.thermal_trip_flag));
	cover property ($rose(flags.supply_low_flag));
endmodule

// ==== lnbfs_sync.sv ====
module lnbfs_sync #(
	parameter int unsigned  W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] sync_q;
	logic [W-1:0] sync_d;

	initial begin
		if (W < 1) $error("lnbfs_sync: width must be at least one");
	end

	// first stage feeds only the second stage
	always_comb begin
		meta_d = async_in;
		sync_d = meta_q;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			// start at the pins' resting level
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_out = sync_q;

endmodule
